// *** rsil_clkdiv.sv ***
/*
  Host clock output divider.
  Assumes clk is the 10 MHz reference; the divide-by-one code passes it through.
*/
`timescale 1ns/1ns
module rsil_clkdiv
  import rsil_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic [2:0] div_sel,
  input wire logic out_disable,
  // Divided clock.
  output logic clkout
);

  // ****************************************************************
  // Divider counter
  // ****************************************************************
  logic [3:0] cnt_r; // Position within one output period.
  logic [3:0] cnt_nxt;
  logic phase_r; // Registered output phase.
  logic phase_nxt;
  logic [3:0] ratio; // Selected divide ratio.

  // Count one output period and hold high for its first ratio/2 counts, rounded down.
  always_comb
  begin
    ratio = DIV_TABLE[div_sel];
    cnt_nxt = (cnt_r >= ratio - 4'h1) ? 4'h0 : cnt_r + 4'h1;
    phase_nxt = (cnt_nxt < {1'b0, ratio[3:1]});
  end

  // Register the counter and phase.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 4'h0;
      phase_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  // A disabled output is held low; ratio one passes the reference.
  assign clkout = out_disable ? 1'b0 : ((ratio == 4'h1) ? clk : phase_r);

endmodule

// *** rsil_core.sv ***
/*
  Status word, interrupt sources and serial status read of the radio control
  interface, plus the supply monitor threshold and host clock divider setting.
  Assumes all inputs, serial pins included, are synchronous to clk and that
  the serial clock runs at no more than a quarter of clk.
*/
`timescale 1ns/1ns

module rsil_core
  import rsil_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Serial control interface.
  input wire logic sel_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  // Power management and mode settings.
  input wire logic receiver_enable,
  input wire logic transmitter_enable,
  input wire logic osc_enable,
  input wire logic supply_monitor_enable,
  input wire logic clkout_control,
  input wire logic wake_timer_enable,
  input wire logic tx_buffer_enable,
  input wire logic rx_queue_enable,
  input wire logic [3:0] fill_threshold,
  input wire logic shared_pin_function,
  input wire logic sw_reset_req,
  // Event sources.
  input wire logic tx_reg_empty,
  input wire logic tx_byte_done,
  input wire logic tx_reg_written,
  input wire logic [4:0] rx_bit_count,
  input wire logic rx_overflow_evt,
  input wire logic wake_elapsed,
  input wire logic [11:0] supply_mv,
  input wire logic ext_irq_in_n,
  // Live radio indications.
  input wire logic rx_empty_flag,
  input wire logic antenna_signal_flag,
  input wire logic strength_above_flag,
  input wire logic signal_quality_flag,
  input wire logic bit_sync_locked_flag,
  input wire logic afc_cycle_toggle,
  input wire logic [6:0] freq_offset_field,
  // Outputs to the host and the rest of the radio.
  output logic irq_out_n,
  output logic osc_run,
  output logic clkout,
  output logic [3:0] threshold_code,
  output logic [2:0] clkout_divider_sel,
  output logic supply_low_flag
);

  // ****************************************************************
  // Serial command interface
  // ****************************************************************
  rsil_ser_t ser_r; // Serial interface state.
  rsil_ser_t ser_nxt;
  logic sck_q_r; // Serial clock of the previous cycle.
  logic [4:0] bit_cnt_r; // Command bits taken so far.
  logic [4:0] bit_cnt_nxt;
  logic [CMD_W-1:0] cmd_r; // Command bits shifted in.
  logic [CMD_W-1:0] cmd_nxt;
  logic [STATUS_W-1:0] sh_r; // Status bits still to shift out.
  logic [STATUS_W-1:0] sh_nxt;
  logic [15:0] cfg_r; // Monitor and divider setting.
  logic [15:0] cfg_nxt;
  logic sck_rise; // Serial clock rising edge.
  logic sck_fall; // Serial clock falling edge.
  logic read_start; // Status read recognised this cycle.
  logic [STATUS_W-1:0] status_word; // Current status word.

  assign sck_rise = sck & ~sck_q_r;
  assign sck_fall = ~sck & sck_q_r;
  // The first bit alone decides between status read and control command.
  assign read_start = (ser_r == RSIL_IDLE) & ~sel_n & sck_rise & ~sdi;

  // Take command bits, recognise reads and load the setting word.
  always_comb
  begin
    ser_nxt = ser_r;
    bit_cnt_nxt = bit_cnt_r;
    cmd_nxt = cmd_r;
    sh_nxt = sh_r;
    cfg_nxt = cfg_r;
    if (sel_n)
    begin
      // Deselect ends any command.
      ser_nxt = RSIL_IDLE;
      bit_cnt_nxt = 5'h00;
    end
    else if (read_start)
    begin
      // Snapshot the status word; its top bit goes out at once.
      ser_nxt = RSIL_READ;
      sh_nxt = status_word;
    end
    else if (ser_r == RSIL_READ)
    begin
      // One status bit per falling serial clock, then zeros.
      if (sck_fall)
        sh_nxt = {sh_r[STATUS_W-2:0], 1'b0};
    end
    else if (sck_rise & (bit_cnt_r < 5'h10))
    begin
      // Control command: collect sixteen bits.
      ser_nxt = RSIL_CMD;
      cmd_nxt = {cmd_r[CMD_W-2:0], sdi};
      bit_cnt_nxt = bit_cnt_r + 5'h01;
      if ((bit_cnt_r == 5'h0F) & (cmd_r[14:7] == CFG_CMD_HI))
        cfg_nxt = {CFG_CMD_HI, cmd_r[6:4], 1'b0, cmd_r[2:0], sdi};
    end
  end

  // Register the serial interface state.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ser_r <= RSIL_IDLE;
      sck_q_r <= 1'b0;
      bit_cnt_r <= 5'h00;
      cmd_r <= '0;
      sh_r <= '0;
      cfg_r <= CFG_RESET;
    end
    else
    begin
      ser_r <= ser_nxt;
      sck_q_r <= sck;
      bit_cnt_r <= bit_cnt_nxt;
      cmd_r <= cmd_nxt;
      sh_r <= sh_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // Data out is the top of the status shifter during a read, else low.
  assign sdo = (ser_r == RSIL_READ) ? sh_r[STATUS_W-1] : 1'b0;
  assign threshold_code = cfg_r[THR_LSB +: 4];
  assign clkout_divider_sel = cfg_r[DIV_SEL_LSB +: 3];

  // ****************************************************************
  // Interrupt sources
  // ****************************************************************
  logic tx_buffer_ready_flag_r; // Transmit buffer ready.
  logic tx_buffer_ready_flag_nxt;
  logic rx_fill_level_flag_r; // Receive fill level reached.
  logic rx_fill_level_flag_nxt;
  logic por_r; // Power-up event.
  logic por_nxt;
  logic tx_underrun_flag_r; // Transmit underrun.
  logic tx_underrun_flag_nxt;
  logic rx_overflow_flag_r; // Receive overflow.
  logic rx_overflow_flag_nxt;
  logic wake_timer_flag_r; // Wake timer elapsed.
  logic wake_timer_flag_nxt;
  logic lbd_irq_r; // Supply low interrupt, released by a read.
  logic lbd_irq_nxt;
  logic lbd_q_r; // Supply low level of the previous cycle.
  logic irq_n_r; // Registered interrupt output.
  logic osc_r; // Registered oscillator run request.
  logic tx_on; // Transmit register path active.
  logic tx_off; // Transmitter and latch both off.
  logic rx_on; // Receive queue path active.
  logic [11:0] trip_mv; // Supply trip level in millivolts.
  logic ext_evt; // External pin active.
  logic ufl_set; // Underrun event this cycle.
  logic fill_set; // Fill level reached this cycle.
  logic pending; // Any interrupt source active.

  assign tx_on = tx_buffer_enable & transmitter_enable;
  assign tx_off = ~tx_buffer_enable & ~transmitter_enable;
  assign rx_on = rx_queue_enable & receiver_enable;
  assign trip_mv = LBD_BASE_MV + 12'(threshold_code * LBD_STEP_MV);
  // Live supply low level, gated by the monitor enable.
  assign supply_low_flag = supply_monitor_enable & (supply_mv < trip_mv);
  assign ext_evt = ~shared_pin_function & ~ext_irq_in_n;
  assign ufl_set = tx_on & tx_byte_done & tx_reg_empty;
  assign fill_set = rx_on & ((rx_bit_count >= {1'b0, fill_threshold})
                             | rx_overflow_evt);

  // Sources set and clear; a set in the clearing cycle always wins.
  always_comb
  begin
    tx_underrun_flag_nxt = tx_underrun_flag_r;
    if (tx_off)
      tx_underrun_flag_nxt = 1'b0;
    if (ufl_set)
      tx_underrun_flag_nxt = 1'b1;

    tx_buffer_ready_flag_nxt = tx_buffer_ready_flag_r;
    if ((tx_reg_written & ~tx_underrun_flag_r) | tx_off)
      tx_buffer_ready_flag_nxt = 1'b0;
    if ((tx_on & tx_reg_empty) | ufl_set)
      tx_buffer_ready_flag_nxt = 1'b1;

    rx_fill_level_flag_nxt = rx_fill_level_flag_r;
    if (~rx_on | (rx_bit_count < {1'b0, fill_threshold}))
      rx_fill_level_flag_nxt = 1'b0;
    if (fill_set)
      rx_fill_level_flag_nxt = 1'b1;

    rx_overflow_flag_nxt = rx_overflow_flag_r;
    if (read_start)
      rx_overflow_flag_nxt = 1'b0;
    if (rx_on & rx_overflow_evt)
      rx_overflow_flag_nxt = 1'b1;

    por_nxt = por_r;
    if (read_start)
      por_nxt = 1'b0;
    if (sw_reset_req)
      por_nxt = 1'b1;

    wake_timer_flag_nxt = wake_timer_flag_r;
    if (read_start)
      wake_timer_flag_nxt = 1'b0;
    if (wake_timer_enable & wake_elapsed)
      wake_timer_flag_nxt = 1'b1;

    // The supply low interrupt fires on entry into the low state.
    lbd_irq_nxt = lbd_irq_r & supply_low_flag;
    if (read_start)
      lbd_irq_nxt = 1'b0;
    if (supply_low_flag & ~lbd_q_r)
      lbd_irq_nxt = 1'b1;
  end

  assign pending = tx_buffer_ready_flag_r | rx_fill_level_flag_r | por_r | tx_underrun_flag_r | rx_overflow_flag_r | wake_timer_flag_r
                   | ext_evt | lbd_irq_r;

  // Register the sources, the interrupt line and the oscillator request.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_buffer_ready_flag_r <= 1'b0;
      rx_fill_level_flag_r <= 1'b0;
      por_r <= 1'b1;
      tx_underrun_flag_r <= 1'b0;
      rx_overflow_flag_r <= 1'b0;
      wake_timer_flag_r <= 1'b0;
      lbd_irq_r <= 1'b0;
      lbd_q_r <= 1'b0;
      irq_n_r <= 1'b1;
      osc_r <= 1'b1;
    end
    else
    begin
      tx_buffer_ready_flag_r <= tx_buffer_ready_flag_nxt;
      rx_fill_level_flag_r <= rx_fill_level_flag_nxt;
      por_r <= por_nxt;
      tx_underrun_flag_r <= tx_underrun_flag_nxt;
      rx_overflow_flag_r <= rx_overflow_flag_nxt;
      wake_timer_flag_r <= wake_timer_flag_nxt;
      lbd_irq_r <= lbd_irq_nxt;
      lbd_q_r <= supply_low_flag;
      irq_n_r <= ~pending;
      // With the clock output off and the radio idle only the enable counts.
      if (clkout_control & ~receiver_enable & ~transmitter_enable)
        osc_r <= osc_enable;
      else
        osc_r <= osc_enable | pending;
    end
  end

  assign irq_out_n = irq_n_r;
  assign osc_run = osc_r;

  // ****************************************************************
  // Status word
  // ****************************************************************
  // Latched flags first, then live bits, then the frequency offset.
  always_comb
  begin
    status_word = '0;
    status_word[ST_TX_READY] = tx_buffer_ready_flag_r;
    status_word[ST_FILL] = rx_fill_level_flag_r;
    status_word[ST_POWER_UP] = por_r;
    status_word[ST_UNDERRUN] = tx_underrun_flag_r;
    status_word[ST_OVERFLOW] = rx_overflow_flag_r;
    status_word[ST_WAKE] = wake_timer_flag_r;
    status_word[ST_EXT] = ext_evt;
    status_word[ST_SUPPLY_LOW] = supply_low_flag;
    status_word[ST_LIVE_LSB +: 6] = {rx_empty_flag, antenna_signal_flag,
                                     strength_above_flag, signal_quality_flag,
                                     bit_sync_locked_flag, afc_cycle_toggle};
    status_word[ST_FREQ_OFFSET_FIELD_SIGN] = freq_offset_field[6];
    status_word[3:0] = freq_offset_field[3:0];
  end

  // ****************************************************************
  // Host clock output
  // ****************************************************************
  rsil_clkdiv u_clkdiv (
    .clk(clk),
    .rst(rst),
    .div_sel(clkout_divider_sel),
    .out_disable(clkout_control),
    .clkout(clkout)
  );

endmodule

// *** rsil_core_checker.sv ***
/*
  Port-level assertions for the status and interrupt block.
  Assumes one clk domain with asynchronous active-high rst.
*/
`timescale 1ns/1ns
module rsil_core_checker
  import rsil_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Serial and settings.
  input wire logic sel_n,
  input wire logic sdo,
  input wire logic receiver_enable,
  input wire logic transmitter_enable,
  input wire logic osc_enable,
  input wire logic supply_monitor_enable,
  input wire logic clkout_control,
  input wire logic wake_timer_enable,
  input wire logic tx_buffer_enable,
  input wire logic shared_pin_function,
  // Event sources.
  input wire logic tx_reg_empty,
  input wire logic wake_elapsed,
  input wire logic [11:0] supply_mv,
  input wire logic ext_irq_in_n,
  // Outputs.
  input wire logic irq_out_n,
  input wire logic osc_run,
  input wire logic clkout,
  input wire logic [3:0] threshold_code,
  input wire logic [2:0] clkout_divider_sel,
  input wire logic supply_low_flag
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Accepted wake event while deselected.
  sequence s_wake;
    wake_elapsed && wake_timer_enable && sel_n;
  endsequence
  // No status read can start while deselected, so nothing clears the flag.
  sequence s_no_read;
    sel_n;
  endsequence
  a_wake_irq_low: assert property (s_wake ##1 s_no_read |-> ##1 !irq_out_n)
    else $error("wake event did not pull the interrupt low");
  a_tx_ready_irq: assert property (tx_buffer_enable && transmitter_enable && tx_reg_empty
    |-> ##2 !irq_out_n)
    else $error("empty transmit register did not raise the interrupt");
  a_ext_pin_follow: assert property (!shared_pin_function && !ext_irq_in_n |=> !irq_out_n)
    else $error("external pin low did not pull the interrupt low");
  a_supply_low_level: assert property (supply_low_flag == (supply_monitor_enable
    && (supply_mv < LBD_BASE_MV + LBD_STEP_MV * threshold_code)))
    else $error("supply low flag disagrees with the trip level");
  a_sdo_idle_low: assert property (sel_n |=> !sdo)
    else $error("serial output not low while deselected");
  a_clkout_held: assert property (clkout_control [*2] |-> !clkout)
    else $error("clock output runs while disabled");
  a_irq_keeps_osc: assert property ((!irq_out_n && !clkout_control) [*2] |-> osc_run)
    else $error("oscillator stopped with an interrupt pending");
  a_osc_gated_off: assert property ((clkout_control && !receiver_enable
    && !transmitter_enable && !osc_enable) [*2] |-> !osc_run)
    else $error("oscillator runs although only its enable governs it");
  a_cfg_quiet: assert property (sel_n [*2] |-> $stable(threshold_code)
    && $stable(clkout_divider_sel))
    else $error("setting changed without a serial command");
endmodule

bind rsil_core rsil_core_checker u_chk (.clk, .rst, .sel_n, .sdo, .receiver_enable,
  .transmitter_enable, .osc_enable, .supply_monitor_enable, .clkout_control,
  .wake_timer_enable, .tx_buffer_enable, .shared_pin_function, .tx_reg_empty,
  .wake_elapsed, .supply_mv, .ext_irq_in_n, .irq_out_n, .osc_run, .clkout,
  .threshold_code, .clkout_divider_sel, .supply_low_flag);

// *** rsil_core_test.sv ***
/*
  Self-checking bench for the status and interrupt block.
  Assumes rsil_host_model drives the serial port; all else is driven here.
*/
`timescale 1ns/1ns
module rsil_core_test
  import rsil_pkg::*;
;
  // Design inputs and outputs.
  logic clk, rst, sel_n, sck, sdi, sdo, receiver_enable, transmitter_enable, osc_enable;
  logic supply_monitor_enable, clkout_control, wake_timer_enable, tx_buffer_enable;
  logic rx_queue_enable, shared_pin_function, sw_reset_req, tx_reg_empty, tx_byte_done;
  logic tx_reg_written, rx_overflow_evt, wake_elapsed, ext_irq_in_n, rx_empty_flag;
  logic antenna_signal_flag, strength_above_flag, signal_quality_flag, bit_sync_locked_flag;
  logic afc_cycle_toggle, irq_out_n, osc_run, clkout, supply_low_flag, low, prev;
  logic [3:0] fill_threshold, threshold_code, code;
  logic [4:0] rx_bit_count;
  logic [11:0] supply_mv, mv;
  logic [6:0] freq_offset_field;
  logic [2:0] clkout_divider_sel, dv;
  logic [7:0] nr, cnt;
  logic en;
  logic [18:0] w;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  // Rows: code, divider, monitor enable, supply mV, low flag, clkout rises in 120 cycles.
  // The clock output is sampled twice per cycle, so the divide-by-one code is seen as well.
  logic [28:0] rows [8] = '{{4'h0, 3'h0, 1'h1, 12'h8C9, 1'h1, 8'h0C},
    {4'h1, 3'h1, 1'h1, 12'h92E, 1'h0, 8'h0F}, {4'h2, 3'h2, 1'h1, 12'h991, 1'h1, 8'h14},
    {4'h5, 3'h3, 1'h1, 12'hABD, 1'h1, 8'h18}, {4'h9, 3'h4, 1'h0, 12'h7D0, 1'h0, 8'h1E},
    {4'hA, 3'h5, 1'h1, 12'hD48, 1'h0, 8'h28}, {4'hE, 3'h6, 1'h1, 12'hE41, 1'h1, 8'h3C},
    {4'hF, 3'h7, 1'h1, 12'hEA5, 1'h1, 8'h78}};

  rsil_core dut (.clk, .rst, .sel_n, .sck, .sdi, .sdo, .receiver_enable, .transmitter_enable,
    .osc_enable, .supply_monitor_enable, .clkout_control, .wake_timer_enable,
    .tx_buffer_enable, .rx_queue_enable, .fill_threshold, .shared_pin_function,
    .sw_reset_req, .tx_reg_empty, .tx_byte_done, .tx_reg_written, .rx_bit_count,
    .rx_overflow_evt, .wake_elapsed, .supply_mv, .ext_irq_in_n, .rx_empty_flag,
    .antenna_signal_flag, .strength_above_flag, .signal_quality_flag,
    .bit_sync_locked_flag, .afc_cycle_toggle, .freq_offset_field, .irq_out_n, .osc_run,
    .clkout, .threshold_code, .clkout_divider_sel, .supply_low_flag);
  rsil_host_model host (.clk, .sel_n, .sck, .sdi, .sdo);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Clock at 100 ns period.
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Cuts a hang short after far more cycles than the run needs.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  // Waits n edges and steps off the edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  // Compares a word result.
  task automatic chk_w(input logic [18:0] got, input logic [18:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Compares a single flag or pin.
  task automatic chk_f(input logic got, input logic exp);
    chk_w({18'h0, got}, {18'h0, exp});
  endtask
  // Reads status and compares the bits under the mask.
  task automatic rd(input logic [18:0] mask, input logic [18:0] exp);
    host.read(w);
    chk_w(w & mask, exp);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rst = 1'h1;
    {receiver_enable, transmitter_enable, supply_monitor_enable, clkout_control} = 4'h0;
    {wake_timer_enable, tx_buffer_enable, rx_queue_enable, sw_reset_req} = 4'h0;
    {tx_reg_empty, tx_byte_done, tx_reg_written, rx_overflow_evt, wake_elapsed} = 5'h0;
    {osc_enable, shared_pin_function, ext_irq_in_n} = 3'h7;
    rx_bit_count = 5'h00;
    fill_threshold = 4'h8;
    supply_mv = 12'hFFF;
    {rx_empty_flag, antenna_signal_flag, strength_above_flag} = 3'h5;
    {signal_quality_flag, bit_sync_locked_flag, afc_cycle_toggle} = 3'h2;
    freq_offset_field = 7'h4A;
    step(3);
    rst = 1'h0;
    step(2);
    chk_f(irq_out_n, 1'h0);
    chk_w({12'h000, threshold_code, clkout_divider_sel}, 19'h0);
    rd(19'h7FFFF, {3'h1, 5'h0, 6'h2A, 1'h1, 4'hA});
    chk_f(irq_out_n, 1'h1);
    {rx_empty_flag, antenna_signal_flag, strength_above_flag} = 3'h2;
    {signal_quality_flag, bit_sync_locked_flag, afc_cycle_toggle} = 3'h5;
    freq_offset_field = 7'h35;
    rd(19'h7FFFF, {3'h0, 5'h0, 6'h15, 1'h0, 4'h5});
    host.send(16'hC81F);
    chk_w({12'h000, threshold_code, clkout_divider_sel}, 19'h0);
    for (int i = 0; i < 8; i++)
    begin
      {code, dv, en, mv, low, nr} = rows[i];
      host.send({8'hC0, dv, 1'h0, code});
      supply_monitor_enable = en;
      supply_mv = mv;
      step(20);
      chk_w({12'h000, threshold_code, clkout_divider_sel}, {12'h000, code, dv});
      chk_f(supply_low_flag, low);
      prev = clkout;
      cnt = 8'h00;
      // Half-period samples: once with clk high, once with clk low.
      repeat (240)
      begin
        #50;
        cnt = cnt + {7'h0, clkout & ~prev};
        prev = clkout;
      end
      chk_w({11'h0, cnt}, {11'h0, nr});
    end
    chk_f(irq_out_n, 1'h0);
    rd(19'h00800, 19'h00800);
    chk_f(irq_out_n, 1'h1);
    rd(19'h00800, 19'h00800);
    supply_monitor_enable = 1'h0;
    // A wake event is ignored while the timer is off.
    for (int i = 0; i < 2; i++)
    begin
      wake_timer_enable = i[0];
      wake_elapsed = 1'h1;
      step(1);
      wake_elapsed = 1'h0;
      step(3);
      chk_f(irq_out_n, ~i[0]);
    end
    rd(19'h02000, 19'h02000);
    chk_f(irq_out_n, 1'h1);
    {osc_enable, shared_pin_function, ext_irq_in_n} = 3'h0;
    step(3);
    chk_f(irq_out_n, 1'h0);
    chk_f(osc_run, 1'h1);
    clkout_control = 1'h1;
    step(3);
    chk_f(osc_run, 1'h0);
    chk_f(clkout, 1'h0);
    {osc_enable, shared_pin_function, ext_irq_in_n, clkout_control} = 4'hE;
    step(3);
    chk_f(irq_out_n, 1'h1);
    {rx_queue_enable, receiver_enable, rx_bit_count} = {2'h3, 5'h07};
    step(3);
    chk_f(irq_out_n, 1'h1);
    rx_bit_count = 5'h08;
    step(3);
    chk_f(irq_out_n, 1'h0);
    rx_bit_count = 5'h00;
    step(3);
    chk_f(irq_out_n, 1'h1);
    {rx_bit_count, rx_overflow_evt} = {5'h10, 1'h1};
    step(1);
    rx_overflow_evt = 1'h0;
    rd(19'h24000, 19'h24000);
    rd(19'h24000, 19'h20000);
    chk_f(irq_out_n, 1'h0);
    receiver_enable = 1'h0;
    step(3);
    chk_f(irq_out_n, 1'h1);
    {tx_buffer_enable, transmitter_enable, tx_reg_empty} = 3'h7;
    step(3);
    chk_f(irq_out_n, 1'h0);
    {tx_reg_written, tx_reg_empty} = 2'h2;
    step(1);
    tx_reg_written = 1'h0;
    step(3);
    chk_f(irq_out_n, 1'h1);
    {tx_reg_empty, tx_byte_done} = 2'h3;
    step(1);
    tx_byte_done = 1'h0;
    rd(19'h48000, 19'h48000);
    {tx_reg_written, tx_reg_empty} = 2'h2;
    step(1);
    tx_reg_written = 1'h0;
    step(3);
    chk_f(irq_out_n, 1'h0);
    {tx_buffer_enable, transmitter_enable} = 2'h0;
    step(3);
    chk_f(irq_out_n, 1'h1);
    sw_reset_req = 1'h1;
    step(1);
    sw_reset_req = 1'h0;
    rd(19'h10000, 19'h10000);
    rst = 1'h1;
    step(1);
    rst = 1'h0;
    step(2);
    chk_w({12'h000, threshold_code, clkout_divider_sel}, 19'h0);
    chk_f(irq_out_n, 1'h0);
    tally_and_finish();
  end
endmodule

// *** rsil_host_model.sv ***
/*
  Host side of the serial control port: sends setting words, reads status.
  Assumes the bench calls its tasks just after a rising clk edge.
*/
`timescale 1ns/1ns
module rsil_host_model
  import rsil_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Serial pins.
  output logic sel_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Idle: deselected, clock still, data line parked away from its last bit.
  initial
  begin
    sel_n = 1'h1;
    sck = 1'h0;
    sdi = 1'h1;
  end

  // Waits n rising edges, then steps off the edge.
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  // Sends a command word MSB first; each clock phase lasts two clk cycles.
  task automatic send(input logic [15:0] w);
    sel_n = 1'h0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi = w[i];
      wt(2);
      sck = 1'h1;
      wt(2);
      sck = 1'h0;
    end
    wt(2);
    sel_n = 1'h1;
    sdi = ~sdi;
    wt(2);
  endtask

  // Reads the status word; a zero on the first serial bit marks it as a read.
  task automatic read(output logic [18:0] w);
    sel_n = 1'h0;
    sdi = 1'h0;
    for (int i = 18; i >= 0; i--)
    begin
      wt(2);
      sck = 1'h1;
      wt(2);
      w[i] = sdo;
      sck = 1'h0;
    end
    wt(2);
    sel_n = 1'h1;
    sdi = 1'h1;
    wt(2);
  endtask
endmodule

// *** rsil_pkg.sv ***
/*
  Shared constants and types for the radio status and interrupt logic.
  Assumes a 10 MHz reference clock and a 16-bit serial command word.
*/
package rsil_pkg;

  // ****************************************************************
  // Command and status word layout
  // ****************************************************************
  // Serial command word width.
  localparam int CMD_W = 16;
  // Status word width: fourteen flags, offset sign and four offset LSBs.
  localparam int STATUS_W = 19;
  // Value of the monitor and divider setting after reset.
  localparam logic [15:0] CFG_RESET = 16'hC000;
  // Upper byte that selects the monitor and divider setting command.
  localparam logic [7:0] CFG_CMD_HI = 8'hC0;
  // Field positions of the monitor and divider setting command.
  localparam int DIV_SEL_LSB = 5;
  localparam int THR_LSB = 0;
  // Status word bit positions, first one shifted out at the top.
  localparam int ST_TX_READY = 18;
  localparam int ST_FILL = 17;
  localparam int ST_POWER_UP = 16;
  localparam int ST_UNDERRUN = 15;
  localparam int ST_OVERFLOW = 14;
  localparam int ST_WAKE = 13;
  localparam int ST_EXT = 12;
  localparam int ST_SUPPLY_LOW = 11;
  localparam int ST_LIVE_LSB = 5;
  localparam int ST_FREQ_OFFSET_FIELD_SIGN = 4;

  // ****************************************************************
  // Supply monitor and clock divider figures
  // ****************************************************************
  // Trip level base of 2250 mV and step of 100 mV per code.
  localparam logic [11:0] LBD_BASE_MV = 12'h8CA;
  localparam logic [11:0] LBD_STEP_MV = 12'h064;
  // Reference clock divide ratios for divider codes 0 to 7.
  localparam logic [3:0] DIV_TABLE [8] = '{4'hA, 4'h8, 4'h6, 4'h5,
                                          4'h4, 4'h3, 4'h2, 4'h1};

  // Serial interface states.
  typedef enum logic [1:0] {RSIL_IDLE, RSIL_CMD, RSIL_READ} rsil_ser_t;

endpackage
